// file: hdl/pci_to_vme_target_window.sv
/*
 Register file and address decode for PCI target windows 1 and 2.
 Assumes the PCI request arrives from logic on aclk, one cycle at a time,
 and that the VMEbus master sequencer downstream consumes the route.
*/
`timescale 1ns/1ns
module pci_to_vme_target_window #(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire tw_pkg::req_t      req,
   output tw_pkg::route_t         route
);

   localparam int NREG = tw_pkg::NUM_WIN * tw_pkg::REGS_PER_WIN;

   // Returns {valid, index}; index = window*4 + register within window
   function automatic logic [3:0] reg_decode(input logic [11:0] a);
      logic [11:0] d;
      reg_decode = 4'h0;
      d = 12'h000;
      if (a >= tw_pkg::W1_CTL_OFS && a <= tw_pkg::W1_XLAT_OFS) begin
         d = a - tw_pkg::W1_CTL_OFS;
         reg_decode = {1'b1, 1'b0, d[3:2]};
      end else if (a >= tw_pkg::W2_CTL_OFS && a <= tw_pkg::W2_XLAT_OFS) begin
         d = a - tw_pkg::W2_CTL_OFS;
         reg_decode = {1'b1, 1'b1, d[3:2]};
      end
      if (a[1:0] != 2'h0) begin
         reg_decode = 4'h0;
      end
   endfunction

   // Writable bits of a register; the rest read as zero
   function automatic logic [31:0] reg_mask(input logic [2:0] idx);
      reg_mask = (idx[1:0] == 2'h0) ? tw_pkg::CTL_MASK : tw_pkg::ADDR_MASK;
   endfunction

   function automatic logic [31:0] reg_reset(input logic [2:0] idx);
      reg_reset = (idx[1:0] == 2'h0) ? tw_pkg::CTL_RESET : tw_pkg::ADDR_RESET;
   endfunction

   logic [31:0]       regs_q [NREG];
   logic              aw_held_q;
   logic [11:0]       awaddr_q;
   logic              w_held_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   tw_pkg::route_t    route_q;
   tw_pkg::route_t    route_d;

   // Bus handshake
   wire         aw_take = s_axi_awvalid && s_axi_awready;
   wire         w_take  = s_axi_wvalid && s_axi_wready;
   wire         do_write = aw_held_q && w_held_q;
   wire [3:0]   wdec    = reg_decode(awaddr_q);
   wire [3:0]   rdec    = reg_decode(s_axi_araddr[11:0]);
   wire         ar_take = s_axi_arvalid && s_axi_arready;
   wire [31:0]  bytemask;
   wire [31:0]  wmerged;

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign route         = route_q;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign bytemask[b*8 +: 8] = {8{wstrb_q[b]}};
      end
   endgenerate

   // Reserved bits are dropped on the way
   assign wmerged = ((regs_q[wdec[2:0]] & ~bytemask) | (wdata_q & bytemask))
                    & reg_mask(wdec[2:0]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         bvalid_q  <= 1'b0;
      end else begin
         aw_held_q <= aw_take | (aw_held_q & ~do_write);
         w_held_q  <= w_take | (w_held_q & ~do_write);
         bvalid_q  <= do_write | (bvalid_q & ~s_axi_bready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= 12'h000;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         bresp_q  <= tw_pkg::RESP_OKAY;
      end else begin
         if (aw_take) awaddr_q <= s_axi_awaddr[11:0];
         if (w_take) wdata_q <= s_axi_wdata;
         if (w_take) wstrb_q <= s_axi_wstrb;
         if (do_write) bresp_q <= wdec[3] ? tw_pkg::RESP_OKAY
                                          : tw_pkg::RESP_SLVERR;
      end
   end

   // Width field resets to 32 bits, all else to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NREG; i++) regs_q[i] <= reg_reset(3'(i));
      end else if (do_write && wdec[3]) begin
         regs_q[wdec[2:0]] <= wmerged;
      end
   end

   // Reads see the masked contents, so reserved bits are zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= tw_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdec[3] ? regs_q[rdec[2:0]] : 32'h0000_0000;
         rresp_q  <= rdec[3] ? tw_pkg::RESP_OKAY : tw_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Per-window decode
   logic [tw_pkg::NUM_WIN-1:0] hit;
   logic [31:0]                wctl [tw_pkg::NUM_WIN];
   logic [15:0]                vhi  [tw_pkg::NUM_WIN];
   wire  [15:0]                pci_hi = req.addr[31:tw_pkg::ADDR_LSB];

   genvar g;
   generate
      for (g = 0; g < tw_pkg::NUM_WIN; g++) begin : g_win
         // 64 KB granularity: only bits 31:16 take part
         wire [15:0] base  = regs_q[g*4+1][31:tw_pkg::ADDR_LSB];
         wire [15:0] bound = regs_q[g*4+2][31:tw_pkg::ADDR_LSB];
         wire [15:0] toff  = regs_q[g*4+3][31:tw_pkg::ADDR_LSB];
         wire        above = pci_hi >= base;
         wire        below = (bound == 16'h0000)
                             || (pci_hi < bound);
         wire        sp_ok = req.io
                             == regs_q[g*4][tw_pkg::CTL_IO_BIT];
         assign wctl[g] = regs_q[g*4];
         // Enable gates the whole window
         assign hit[g]  = regs_q[g*4][tw_pkg::CTL_EN_BIT] && above && below
                          && sp_ok;
         // Carry out of bit 31 is dropped by design
         assign vhi[g]  = pci_hi + toff;
      end
   endgenerate

   // Window 1 wins if both overlap; overlapping setups are a software error
   wire            sel   = !hit[0];
   wire [31:0]     ctl   = wctl[sel];
   wire tw_pkg::width_t max_width =
      tw_pkg::width_t'(ctl[tw_pkg::CTL_WIDTH_LSB +: 2]);
   wire tw_pkg::space_t vme_space =
      tw_pkg::space_t'(ctl[tw_pkg::CTL_SPACE_LSB +: 3]);
   wire            wide  = (vme_space == tw_pkg::SPACE_A24)
                           || (vme_space == tw_pkg::SPACE_A32);
   wire            is_io = ctl[tw_pkg::CTL_IO_BIT];

   always_comb begin
      route_d          = '0;
      route_d.hit      = req.valid && (hit != '0);
      route_d.miss     = req.valid && (hit == '0);
      route_d.window   = sel;
      route_d.vme_addr = {vhi[sel], req.addr[tw_pkg::ADDR_LSB-1:0]};
      route_d.width    = max_width;
      route_d.space    = vme_space;
      route_d.program_data_select = ctl[tw_pkg::CTL_PROGRAM_BIT];
      route_d.supervisor          = ctl[tw_pkg::CTL_SUPER_BIT];
      route_d.blt      = ctl[tw_pkg::CTL_BLOCK_BIT] && wide
                         && (max_width != tw_pkg::WIDTH_64);
      route_d.mblt     = wide && (max_width == tw_pkg::WIDTH_64);
      // I/O windows are always coupled
      route_d.posted   = ctl[tw_pkg::CTL_POSTED_BIT] && !is_io
                         && req.write;
      if (!route_d.hit) begin
         route_d.window   = 1'b0;
         route_d.vme_addr = 32'h0000_0000;
         route_d.width    = tw_pkg::WIDTH_8;
         route_d.space    = tw_pkg::SPACE_A16;
         route_d.program_data_select = 1'b0;
         route_d.supervisor          = 1'b0;
         route_d.blt      = 1'b0;
         route_d.mblt     = 1'b0;
         route_d.posted   = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         route_q <= '0;
      end else begin
         route_q <= route_d;
      end
   end

endmodule

// file: hdl/tw_pkg.sv
/*
 Constants, field layouts and carrier types for the PCI-side target
 windows 1 and 2 of the PCI-to-VMEbus bridge.
 Assumes a 12-bit byte address on the AXI4-Lite register port.
*/
// Summary of operation
// - A window decodes only while its enable bit is 1.
// - Writes are posted when the posted-write bit is set, but never for I/O.
// - Width field 00/01/10/11 selects 8/16/32/64 bits and resets to 10.
// - Space field selects A16, A24, A32, CR/CSR, User1, User2; 011, 100 reserved.
// - Program/data bit picks program or data AM codes; privilege bit picks supervisor.
// - Cycle-type bit asks for block transfers only in A24/A32 at 8, 16 or 32 bits.
// - A24/A32 at 64-bit width may use MBLT whatever the cycle-type bit says.
// - Space-select bit 0 answers PCI memory space, 1 answers PCI I/O space.
// - The base register holds the lowest PCI address decoded.
// - An address decodes when at or above base and strictly below bound.
// - A bound of zero means no upper limit.
// - Windows 1 and 2 resolve base, bound and offset on bits 31 to 16.
// - VMEbus address bits 31:16 are PCI bits 31:16 plus the offset, mod 2^16.
package tw_pkg;

   localparam int NUM_WIN = 2;
   localparam int REGS_PER_WIN = 4;

   localparam logic [11:0] W1_CTL_OFS   = 12'h114;
   localparam logic [11:0] W1_BASE_OFS  = 12'h118;
   localparam logic [11:0] W1_LIMIT_OFS = 12'h11C;
   localparam logic [11:0] W1_XLAT_OFS  = 12'h120;
   localparam logic [11:0] W2_CTL_OFS   = 12'h128;
   localparam logic [11:0] W2_BASE_OFS  = 12'h12C;
   localparam logic [11:0] W2_LIMIT_OFS = 12'h130;
   localparam logic [11:0] W2_XLAT_OFS  = 12'h134;

   localparam int CTL_EN_BIT      = 31;
   localparam int CTL_POSTED_BIT  = 30;
   localparam int CTL_WIDTH_LSB   = 22;
   localparam int CTL_SPACE_LSB   = 16;
   localparam int CTL_PROGRAM_BIT = 14;
   localparam int CTL_SUPER_BIT   = 12;
   localparam int CTL_BLOCK_BIT   = 8;
   localparam int CTL_IO_BIT      = 0;
   localparam int ADDR_LSB        = 16;

   localparam logic [31:0] CTL_MASK   = 32'hC0C7_5101;
   localparam logic [31:0] ADDR_MASK  = 32'hFFFF_0000;
   localparam logic [31:0] CTL_RESET  = 32'h0080_0000;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WIDTH_8  = 2'h0,
      WIDTH_16 = 2'h1,
      WIDTH_32 = 2'h2,
      WIDTH_64 = 2'h3
   } width_t;

   typedef enum logic [2:0] {
      SPACE_A16   = 3'h0,
      SPACE_A24   = 3'h1,
      SPACE_A32   = 3'h2,
      SPACE_RSV3  = 3'h3,
      SPACE_RSV4  = 3'h4,
      SPACE_CRCSR = 3'h5,
      SPACE_USER1 = 3'h6,
      SPACE_USER2 = 3'h7
   } space_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        io;
      logic        write;
   } req_t;

   typedef struct packed {
      logic        hit;
      logic        miss;
      logic        window;
      logic [31:0] vme_addr;
      width_t      width;
      space_t      space;
      logic        program_data_select;
      logic        supervisor;
      logic        blt;
      logic        mblt;
      logic        posted;
   } route_t;

endpackage

// file: sim/tw_chk.sv
/*
 Checker for the target window block: bus answers and route checks.
 Sees only the top module ports on aclk; bound after the module.
*/
`timescale 1ns/1ns
module tw_chk (
   input wire logic           aclk,
   input wire logic           aresetn,
   input wire logic           s_axi_awvalid,
   input wire logic           s_axi_awready,
   input wire logic           s_axi_wvalid,
   input wire logic           s_axi_wready,
   input wire logic           s_axi_bvalid,
   input wire logic           s_axi_bready,
   input wire logic           s_axi_arvalid,
   input wire logic           s_axi_arready,
   input wire logic           s_axi_rvalid,
   input wire tw_pkg::req_t   req,
   input wire tw_pkg::route_t route
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read not answered");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   req_answer_a: assert property (req.valid |=> route.hit ^ route.miss)
      else $error("request not answered once");
   idle_quiet_a: assert property (!req.valid |=> !route.hit && !route.miss)
      else $error("route without request");
   low_addr_a: assert property (
      route.hit |-> route.vme_addr[15:0] == $past(req.addr[15:0]))
      else $error("low address bits changed");
   posted_io_a: assert property (
      route.posted |-> !$past(req.io) && $past(req.write))
      else $error("posted outside memory write");
   blt_gate_a: assert property (route.blt |->
      route.width != tw_pkg::WIDTH_64 &&
      route.space inside {tw_pkg::SPACE_A24, tw_pkg::SPACE_A32})
      else $error("block transfer in wrong mode");
   mblt_gate_a: assert property (route.mblt |->
      route.width == tw_pkg::WIDTH_64 &&
      route.space inside {tw_pkg::SPACE_A24, tw_pkg::SPACE_A32})
      else $error("wide block transfer in wrong mode");
endmodule
bind pci_to_vme_target_window tw_chk tw_chk_i (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .req, .route
);

// file: sim/pci_master_model.sv
/*
 Behavioural PCI master placing single requests into the windows.
 Assumes the window samples req at every rising edge of aclk.
*/
`timescale 1ns/1ns
module pci_master_model (
   input  wire logic   aclk,
   output tw_pkg::req_t req
);
   initial req = '0;
   // Idle fields are inverted so a stale request never looks current
   task automatic send(input logic [31:0] a, input logic io, wr);
      @(posedge aclk);
      req <= '{valid: 1'h1, addr: a, io: io, write: wr};
      @(posedge aclk);
      req <= '{valid: 1'h0, addr: ~a, io: ~io, write: ~wr};
   endtask
endmodule

// file: sim/pci_to_vme_target_window_tb.sv
/*
 Self-checking bench for the target window block.
 Registers go over AXI4-Lite, requests through the master model.
*/
`timescale 1ns/1ns
module pci_to_vme_target_window_tb;
   logic           aclk = 1'h0;
   logic           aresetn = 1'h0;
   logic [11:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]    s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0]     s_axi_wstrb = '0;
   logic           s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic           s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
   logic           s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]     s_axi_bresp, s_axi_rresp, rs;
   tw_pkg::req_t   req;
   tw_pkg::route_t route;
   int             err_count = 0, n_compared = 0, cyc = 0;
   always #4 aclk = ~aclk;
   pci_to_vme_target_window pci_to_vme_target_window_i (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .req, .route);
   pci_master_model pci_master_model_i (.aclk, .req);
   task automatic chk(input logic [63:0] g, e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      rs = s_axi_bresp;
   endtask
   task automatic rd_reg(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   // Route stands one cycle only, so it is sampled just after its edge
   task automatic look(input logic [31:0] a, input logic io, w, h,
                       input logic [31:0] va);
      pci_master_model_i.send(a, io, w);
      #1;
      chk({route.hit, route.miss}, {h, !h});
      chk(route.vme_addr, h ? va : 32'h0);
   endtask
   task automatic t_reset;
      for (int i = 0; i < 8; i++) begin
         rd_reg((i < 4 ? 12'h114 : 12'h128) + 12'(4 * (i % 4)));
         chk(rd, (i % 4) != 0 ? 32'h0 : tw_pkg::CTL_RESET);
      end
      rd_reg(12'h200);
      chk({rs, rd}, {tw_pkg::RESP_SLVERR, 32'h0});
      wr(12'h200, 32'hFFFF_FFFF);
      chk(rs, tw_pkg::RESP_SLVERR);
      wr(12'h114, 32'hFFFF_FFFF);
      chk(rs, tw_pkg::RESP_OKAY);
      rd_reg(12'h114);
      chk(rd, tw_pkg::CTL_MASK);
      wr(12'h134, 32'hFFFF_FFFF);
      rd_reg(12'h134);
      chk(rd, tw_pkg::ADDR_MASK);
      $display("test reset and fields done");
   endtask
   task automatic t_decode;
      wr(12'h118, 32'h1000_0000);
      wr(12'h11C, 32'h2000_0000);
      wr(12'h120, 32'h1234_0000);
      wr(12'h114, 32'h8082_5100);
      look(32'h0FFF_FFFC, 1'h0, 1'h0, 1'h0, 32'h0);
      look(32'h1000_0000, 1'h0, 1'h0, 1'h1, 32'h2234_0000);
      chk({route.program_data_select, route.supervisor, route.blt},
          3'h7);
      look(32'h1FFF_ABCD, 1'h0, 1'h1, 1'h1, 32'h3233_ABCD);
      look(32'h2000_0000, 1'h0, 1'h0, 1'h0, 32'h0);
      look(32'h1000_0000, 1'h1, 1'h0, 1'h0, 32'h0);
      wr(12'h114, 32'h8082_0000);
      look(32'h1000_0000, 1'h0, 1'h0, 1'h1, 32'h2234_0000);
      chk({route.program_data_select, route.supervisor, route.blt},
          3'h0);
      wr(12'h114, 32'h0082_0000);
      look(32'h1000_0000, 1'h0, 1'h0, 1'h0, 32'h0);
      $display("test decode done");
   endtask
   task automatic t_modes;
      logic ab;
      for (int w = 0; w < 4; w++)
         for (int s = 0; s < 8; s++) begin
            wr(12'h114, 32'h8000_0100 | 32'(w) << 22 | 32'(s) << 16);
            look(32'h1000_0000, 1'h0, 1'h0, 1'h1, 32'h2234_0000);
            ab = (s == 1 || s == 2);
            chk({route.width, route.space}, 32'(w * 8 + s));
            chk({route.blt, route.mblt}, {ab && w != 3, ab && w == 3});
         end
      $display("test modes done");
   endtask
   task automatic t_window2;
      wr(12'h12C, 32'h8000_0000);
      wr(12'h130, 32'h0);
      wr(12'h134, 32'hF000_0000);
      wr(12'h128, 32'hC080_0000);
      look(32'h8001_0004, 1'h0, 1'h1, 1'h1, 32'h7001_0004);
      chk({route.window, route.posted}, 2'h3);
      look(32'hFFFF_FFF0, 1'h0, 1'h0, 1'h1, 32'hEFFF_FFF0);
      wr(12'h128, 32'hC080_0001);
      look(32'h8001_0004, 1'h0, 1'h1, 1'h0, 32'h0);
      look(32'h8001_0004, 1'h1, 1'h1, 1'h1, 32'h7001_0004);
      chk({route.window, route.posted}, 2'h2);
      $display("test window two done");
   endtask
   // Mid-run reset must bring back the values the windows start with
   task automatic t_rerun;
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd_reg(12'h128);
      chk(rd, tw_pkg::CTL_RESET);
      rd_reg(12'h12C);
      chk(rd, 32'h0);
      $display("test second reset done");
   endtask
   task automatic summarize;
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Whole run needs a few hundred cycles; the ceiling leaves ample margin
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         summarize;
      end
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset;
      t_decode;
      t_modes;
      t_window2;
      t_rerun;
      summarize;
   end
endmodule
